// [ffl_pkg.sv]
/*
 * Shared constants and carrier types for the flash driver fault-flag block.
 * Assumes the two-wire control slave outside this block decodes each
 * register access into a one-cycle read or write strobe with an address.
 */
package ffl_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] FFL_ADDR_THERM_SET = 8'h02;
   localparam logic [7:0] FFL_ADDR_ENABLE = 8'h0a;
   localparam logic [7:0] FFL_ADDR_FLAGS = 8'h0b;

   // ==========================================================
   // reset values
   localparam logic [7:0] FFL_FLAGS_RESET = 8'h00;
   localparam logic [7:0] FFL_THERM_SET_RESET = 8'h00;
   localparam logic [7:0] FFL_ENABLE_RESET = 8'h00;

   // ==========================================================
   // flag bit positions
   localparam int FFL_BIT_TX = 7;
   localparam int FFL_BIT_THERM = 6;
   localparam int FFL_BIT_INPUT_MONITOR = 5;
   localparam int FFL_BIT_UNDERVOLTAGE = 4;
   localparam int FFL_BIT_OVERVOLTAGE = 3;
   localparam int FFL_BIT_SHORT = 2;
   localparam int FFL_BIT_TSD = 1;
   localparam int FFL_BIT_TIMEOUT = 0;

   // faults inhibit operation, the rest only record
   localparam logic [7:0] FFL_FAULT_MASK = 8'h16;

   // ==========================================================
   // control fields
   localparam int FFL_EN_THERM_BIT = 7;
   localparam int FFL_EN_TX_BIT = 6;
   localparam int FFL_THERM_MODE_BIT = 4;
   localparam int FFL_THERM_LVL_LSB = 0;
   localparam int FFL_THERM_LVL_W = 4;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ffl_req_t;

   typedef struct packed {
      logic tx_pin;
      logic input_voltage_flash_monitor;
      logic undervoltage_lockout;
      logic overvoltage_protect;
      logic short_det;
      logic tsd;
      logic timeout;
   } ffl_cond_t;

endpackage

// [ffl_therm_cmp.sv]
/*
 * Thermistor trip comparator: sense code against programmed trip level.
 * Assumes the sense code is already sampled on clock and falls as the
 * thermistor heats.
 */
`timescale 1ns/10ps
module ffl_therm_cmp
   import ffl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control
   input wire logic enable,
   input wire logic [ffl_pkg::FFL_THERM_LVL_W-1:0] trip_level,
   // sense
   input wire logic [7:0] sense_code,
   // result
   output logic trip
);
   import ffl_pkg::*;

   logic [7:0] threshold;

   // ==========================================================
   // comparator
   // coarse level scaled to the top nibble of the sense range
   assign threshold = {trip_level, 4'h0};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trip <= 1'b0;
      end else begin
         trip <= enable && (sense_code <= threshold);
      end
   end

   a_trip_compare: assert property (@(posedge clock) disable iff (!rst_n)
      (enable && sense_code <= threshold) |=> trip)
      else $error("thermistor trip not raised below threshold");

   a_trip_disabled: assert property (@(posedge clock) disable iff (!rst_n)
      !enable |=> !trip)
      else $error("thermistor trip raised while disabled");

endmodule

// [ffl_flags.sv]
/*
 * Event and fault flag register of the flash driver, with its thermistor
 * comparator, thermistor settings and enable register.
 * Assumes the control-bus slave delivers one-cycle read and write strobes,
 * and that the analog monitors present their conditions as clocked levels.
 */
`timescale 1ns/10ps
module ffl_flags
   import ffl_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register access
   input wire ffl_pkg::ffl_req_t req,
   output logic [7:0] reg_rdata,
   // conditions
   input wire ffl_pkg::ffl_cond_t cond,
   input wire logic [7:0] temp_sense,
   // control out
   output logic op_inhibit,
   output logic led_current_reduce
);
   import ffl_pkg::*;

   logic [7:0] flags;
   logic [7:0] therm_set;
   logic [7:0] enable_reg;
   logic [7:0] next_flags;
   logic [7:0] set_vec;
   logic therm_trip;
   logic tx_evt;
   logic rd_flags;
   logic therm_normal;

   function automatic logic hit(input ffl_req_t r, input logic [7:0] a);
      hit = r.addr == a;
   endfunction

   // ==========================================================
   // thermistor comparator
   ffl_therm_cmp u_cmp (
      .clock(clock),
      .rst_n(rst_n),
      .enable(enable_reg[FFL_EN_THERM_BIT]),
      .trip_level(therm_set[FFL_THERM_LVL_LSB +: FFL_THERM_LVL_W]),
      .sense_code(temp_sense),
      .trip(therm_trip)
   );

   // ==========================================================
   // flag sources
   assign tx_evt = cond.tx_pin && enable_reg[FFL_EN_TX_BIT];
   assign therm_normal = therm_set[FFL_THERM_MODE_BIT];
   assign rd_flags = req.rd && hit(req, FFL_ADDR_FLAGS);

   always_comb begin
      set_vec = 8'h00;
      set_vec[FFL_BIT_TX] = tx_evt;
      set_vec[FFL_BIT_THERM] = therm_trip;
      set_vec[FFL_BIT_INPUT_MONITOR] = cond.input_voltage_flash_monitor;
      set_vec[FFL_BIT_UNDERVOLTAGE] = cond.undervoltage_lockout;
      set_vec[FFL_BIT_OVERVOLTAGE] = cond.overvoltage_protect;
      set_vec[FFL_BIT_SHORT] = cond.short_det;
      set_vec[FFL_BIT_TSD] = cond.tsd;
      set_vec[FFL_BIT_TIMEOUT] = cond.timeout;
   end

   // a read drops stale bits; live conditions win over the clear
   always_comb begin
      if (rd_flags) begin
         next_flags = set_vec;
      end else begin
         next_flags = flags | set_vec;
      end
   end

   // ==========================================================
   // flag register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FFL_FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   // only fault bits gate operation; flags merely record
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         op_inhibit <= 1'b0;
      end else begin
         op_inhibit <= |(next_flags & FFL_FAULT_MASK);
      end
   end

   // monitor mode reports the trip but leaves the current alone
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         led_current_reduce <= 1'b0;
      end else begin
         led_current_reduce <= tx_evt || (therm_trip && therm_normal);
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         therm_set <= FFL_THERM_SET_RESET;
         enable_reg <= FFL_ENABLE_RESET;
      end else if (req.wr) begin
         if (hit(req, FFL_ADDR_THERM_SET)) begin
            therm_set <= req.wdata;
         end
         if (hit(req, FFL_ADDR_ENABLE)) begin
            enable_reg <= req.wdata;
         end
      end
   end

   // ==========================================================
   // read data, held until the next read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            FFL_ADDR_FLAGS: begin
               reg_rdata <= flags;
            end
            FFL_ADDR_THERM_SET: begin
               reg_rdata <= therm_set;
            end
            FFL_ADDR_ENABLE: begin
               reg_rdata <= enable_reg;
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // checks
   a_read_snapshot: assert property (@(posedge clock) disable iff (!rst_n)
      rd_flags |=> reg_rdata == $past(flags))
      else $error("flag read did not return latched flags");

   a_input_monitor_sets: assert property (@(posedge clock) disable iff (!rst_n)
      cond.input_voltage_flash_monitor |=> flags[FFL_BIT_INPUT_MONITOR])
      else $error("input monitor flag not set");

   a_overvoltage_sets: assert property (@(posedge clock) disable iff (!rst_n)
      cond.overvoltage_protect |=> flags[FFL_BIT_OVERVOLTAGE])
      else $error("overvoltage flag not set");

   a_tsd_fault: assert property (@(posedge clock) disable iff (!rst_n)
      cond.tsd |=> flags[FFL_BIT_TSD] && op_inhibit)
      else $error("thermal shutdown did not inhibit");

   a_fault_holds: assert property (@(posedge clock) disable iff (!rst_n)
      (op_inhibit && !rd_flags) |=> op_inhibit)
      else $error("inhibit released without a flag read");

   a_flag_free: assert property (@(posedge clock) disable iff (!rst_n)
      ((flags & FFL_FAULT_MASK) == 8'h00) |-> !op_inhibit)
      else $error("non-fault flag inhibited operation");

   a_reassert: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_flags && cond.tsd) |=> flags[FFL_BIT_TSD] && op_inhibit)
      else $error("persisting fault lost on read");

   a_therm_flag: assert property (@(posedge clock) disable iff (!rst_n)
      therm_trip |=> flags[FFL_BIT_THERM])
      else $error("thermistor flag not set");

   a_monitor_mode: assert property (@(posedge clock) disable iff (!rst_n)
      (therm_trip && !therm_normal && !tx_evt) |=> !led_current_reduce)
      else $error("monitor mode changed current");

   a_tx_gate: assert property (@(posedge clock) disable iff (!rst_n)
      (cond.tx_pin && !enable_reg[FFL_EN_TX_BIT] && !flags[FFL_BIT_TX] && !rd_flags)
      |=> !flags[FFL_BIT_TX])
      else $error("disabled transmit pin set its flag");

   a_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_flags && set_vec == 8'h00) |=> (flags == 8'h00) && !op_inhibit)
      else $error("read did not clear ended conditions");

   // an enabled transmit event must show in its flag and in the current reduction one cycle later
   a_tx_sets: assert property (@(posedge clock) disable iff (!rst_n)
      tx_evt |=> flags[FFL_BIT_TX] && led_current_reduce)
      else $error("enabled transmit event not recorded");

   a_event_no_block: assert property (@(posedge clock) disable iff (!rst_n)
      (((set_vec & FFL_FAULT_MASK) == 8'h00) && ((flags & FFL_FAULT_MASK) == 8'h00)) |=> !op_inhibit)
      else $error("event flag blocked operation");

   a_short_fault: assert property (@(posedge clock) disable iff (!rst_n)
      cond.short_det |=> flags[FFL_BIT_SHORT] && op_inhibit)
      else $error("short fault did not inhibit");

   a_undervoltage_fault: assert property (@(posedge clock) disable iff (!rst_n)
      cond.undervoltage_lockout |=> flags[FFL_BIT_UNDERVOLTAGE] && op_inhibit)
      else $error("undervoltage fault did not inhibit");

   a_therm_reduce: assert property (@(posedge clock) disable iff (!rst_n)
      (therm_trip && therm_normal) |=> led_current_reduce)
      else $error("normal mode trip did not reduce current");

   a_rdata_holds: assert property (@(posedge clock) disable iff (!rst_n)
      !req.rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

endmodule

// [ffl_host.sv]
/*
 * Host model on the control bus of the fault-flag block.
 * Assumes the bench calls its access task and that one request is
 * issued at a time, 1 ns after the bench clock edge.
 */
`timescale 1ns/10ps
module ffl_host (
   // clock
   input wire logic clock,
   // register access
   output ffl_pkg::ffl_req_t req
);
   import ffl_pkg::*;
   // ==========================================================
   // bus cycles
   initial begin
      req = '0;
   end
   // one-cycle strobe, dropped only after the taking edge
   task automatic access(input logic rd, input logic wr, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge clock);
      #1 req = '{rd, wr, a, d};
      @(posedge clock);
      #1 req = '0;
   endtask
endmodule

// [tb_ffl_flags.sv]
/*
 * Self-checking bench for the fault-flag block, with the host model.
 * Assumes the block answers reads one cycle after the strobe.
 */
`timescale 1ns/10ps
module tb_ffl_flags;
   import ffl_pkg::*;
   logic clock, rst_n, rd_d, op_inhibit, led_current_reduce;
   logic [7:0] reg_rdata, temp_sense;
   ffl_req_t req;
   ffl_cond_t cond;
   logic [7:0] exp_q[$];
   int miscompares = 0, check_count = 0, cycles = 0, k, seed;
   ffl_host ffl_host_i (.clock(clock), .req(req));
   ffl_flags ffl_flags_i (.clock(clock), .rst_n(rst_n), .req(req), .reg_rdata(reg_rdata),
      .cond(cond), .temp_sense(temp_sense), .op_inhibit(op_inhibit),
      .led_current_reduce(led_current_reduce));
   // ==========================================================
   // helpers
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      ffl_host_i.access(1'b1, 1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ffl_host_i.access(1'b0, 1'b1, a, d);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================================
   // read-data watcher and hang guard
   always @(posedge clock) begin
      rd_d <= req.rd;
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   always @(negedge clock) begin
      if (rd_d === 1'b1) begin
         chk(reg_rdata, exp_q.pop_front());
      end
   end
   // ==========================================================
   // tests
   initial begin
      seed = $urandom(32'h033f);
      rst_n = 1'b0;
      cond = '0;
      temp_sense = 8'hff;
      tick(2);
      rst_n = 1'b1;
      rd(FFL_ADDR_FLAGS, 8'h00);
      rd(FFL_ADDR_THERM_SET, 8'h00);
      rd(8'h33, 8'h00);
      wr(FFL_ADDR_FLAGS, 8'hff);
      rd(FFL_ADDR_FLAGS, 8'h00);
      $display("test reset and refused accesses done");
      // one pulse per condition except the transmit pin; only faults may inhibit
      for (k = 0; k < 6; k++) begin
         tick(1);
         cond[k] = 1'b1;
         tick(1);
         cond[k] = 1'b0;
         tick(3);
         chk(op_inhibit, 8'(FFL_FAULT_MASK[k]));
         rd(FFL_ADDR_FLAGS, 8'h01 << k);
         tick(1);
         chk(op_inhibit, 8'h00);
         rd(FFL_ADDR_FLAGS, 8'h00);
      end
      $display("test condition pulses done");
      // persisting fault survives a read
      cond.tsd = 1'b1;
      tick(2);
      rd(FFL_ADDR_FLAGS, 8'h02);
      tick(1);
      chk(op_inhibit, 8'h01);
      cond.tsd = 1'b0;
      rd(FFL_ADDR_FLAGS, 8'h02);
      rd(FFL_ADDR_FLAGS, 8'h00);
      $display("test persisting fault done");
      // transmit pin only counts once enabled
      cond.tx_pin = 1'b1;
      tick(3);
      chk(led_current_reduce, 8'h00);
      cond.tx_pin = 1'b0;
      rd(FFL_ADDR_FLAGS, 8'h00);
      wr(FFL_ADDR_ENABLE, 8'h40);
      rd(FFL_ADDR_ENABLE, 8'h40);
      cond.tx_pin = 1'b1;
      tick(3);
      chk(led_current_reduce, 8'h01);
      chk(op_inhibit, 8'h00);
      cond.tx_pin = 1'b0;
      rd(FFL_ADDR_FLAGS, 8'h80);
      rd(FFL_ADDR_FLAGS, 8'h00);
      $display("test transmit events done");
      // thermistor: random codes above threshold, then the boundary
      wr(FFL_ADDR_THERM_SET, 8'h08);
      wr(FFL_ADDR_ENABLE, 8'hc0);
      for (k = 0; k < 4; k++) begin
         temp_sense = 8'h81 + 8'($urandom_range(0, 126));
         tick(3);
         rd(FFL_ADDR_FLAGS, 8'h00);
      end
      temp_sense = 8'h80;
      tick(3);
      chk(led_current_reduce, 8'h00);
      rd(FFL_ADDR_FLAGS, 8'h40);
      wr(FFL_ADDR_THERM_SET, 8'h18);
      tick(3);
      chk(led_current_reduce, 8'h01);
      temp_sense = 8'hff;
      tick(3);
      chk(led_current_reduce, 8'h00);
      rd(FFL_ADDR_FLAGS, 8'h40);
      rd(FFL_ADDR_FLAGS, 8'h00);
      $display("test thermistor done");
      tick(2);
      tally_and_finish();
   end
endmodule
